/* File: frame_list_timer.sv */
/*
 Frame timing and list pointer logic: bulk current pointer, done list head,
 frame interval, remaining counter, frame number and thresholds, behind APB.
 Assumes a list engine on the same clock and a bit-time strobe from a pin.
*/
// The APB register port was left to the implementer.
`timescale 1ns/1ps
module frame_list_timer (
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        rstn_in,
	// APB slave
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [31:0] paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic [31:0]      prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	// Bit-time strobe from the serial engine
	input  wire logic        bit_tick_in,
	// List engine requests
	input  wire logic        bulk_served_in,
	input  wire logic [31:0] bulk_next_in,
	input  wire logic        bulk_end_in,
	input  wire logic [31:0] bulk_head_in,
	input  wire logic        td_complete_in,
	input  wire logic [31:0] td_addr_in,
	input  wire logic        done_wb_req_in,
	input  wire logic        xact_busy_in,
	// Shared area writes and frame events
	output logic             td_link_wr_out,
	output logic [31:0]      td_link_data_out,
	output logic             done_wb_out,
	output logic [31:0]      done_wb_data_out,
	output logic             sof_out,
	output logic             fn_wb_out,
	output logic [15:0]      frame_number_out,
	// Scheduling decisions
	output logic [31:0]      bulk_current_out,
	output logic [14:0]      largest_packet_count_out,
	output logic             periodic_priority_out,
	output logic             periodic_go_out,
	output logic             ls_commit_ok_out,
	output logic             irq_out
);
	// Current and next state
	frame_list_pkg::state_t st_reg;
	frame_list_pkg::state_t st_next;
	// Synchronised strobe and its rising edge
	logic        tick_sync;
	logic        tick;
	// Bus access decode
	logic        acc;
	logic        wr;
	logic        mapped;
	logic [31:0] rd;

	// Strobe passes two flops before use
	bit_tick_sync u_tick_sync (
		.clk_in    (clk_in),
		.rstn_in   (rstn_in),
		.level_in  (bit_tick_in),
		.level_out (tick_sync)
	);

	assign tick = tick_sync & ~st_reg.tick_d;
	assign acc  = psel_in & penable_in & st_reg.pready;
	assign wr   = acc & pwrite_in;

	// Read mux; reserved bits read as zero
	always_comb begin
		rd     = 32'h00000000;
		mapped = 1'b1;
		case (paddr_in)
			frame_list_pkg::BULK_CUR_ADDR:  rd = st_reg.bulk_cur;
			frame_list_pkg::DONE_HEAD_ADDR: rd = st_reg.done_head;
			frame_list_pkg::FM_INTV_ADDR: begin
				rd[frame_list_pkg::TOGGLE_BIT] = st_reg.interval_toggle;
				rd[frame_list_pkg::FULL_SPEED_LARGEST_PACKET_MSB:frame_list_pkg::FULL_SPEED_LARGEST_PACKET_LSB] = st_reg.full_speed_largest_packet;
				rd[13:0] = st_reg.fi;
			end
			frame_list_pkg::FM_REM_ADDR: begin
				rd[frame_list_pkg::TOGGLE_BIT] = st_reg.remaining_toggle;
				rd[13:0] = st_reg.fr;
			end
			frame_list_pkg::FM_NUM_ADDR:    rd[15:0] = st_reg.fn;
			frame_list_pkg::PER_START_ADDR: rd[13:0] = st_reg.ps;
			frame_list_pkg::LS_THR_ADDR:    rd[11:0] = st_reg.low_speed_threshold;
			frame_list_pkg::CTRL_ADDR: begin
				rd[frame_list_pkg::CTRL_BULK_EN] = st_reg.bulk_en;
				rd[frame_list_pkg::CTRL_FILLED]  = st_reg.filled;
				rd[frame_list_pkg::CTRL_OPER]    = st_reg.oper;
			end
			frame_list_pkg::STATUS_ADDR: begin
				rd[frame_list_pkg::ST_SOF] = st_reg.sf_st;
				rd[frame_list_pkg::ST_WDH] = st_reg.wdh_st;
			end
			frame_list_pkg::INT_EN_ADDR: begin
				rd[frame_list_pkg::ST_SOF] = st_reg.sf_en;
				rd[frame_list_pkg::ST_WDH] = st_reg.wdh_en;
				rd[frame_list_pkg::EN_MIE] = st_reg.master_interrupt_enable;
			end
			default: mapped = 1'b0;
		endcase
	end

	// Next-state logic of the whole block
	always_comb begin
		st_next          = st_reg;
		st_next.tick_d   = tick_sync;
		st_next.sof_p    = 1'b0;
		st_next.fnwb_p   = 1'b0;
		st_next.tdwr_p   = 1'b0;
		st_next.donewb_p = 1'b0;
		st_next.oper_d   = st_reg.oper;

		// APB: no wait state, answer registered in the setup cycle
		st_next.pready  = psel_in & ~penable_in;
		st_next.pslverr = psel_in & ~penable_in & ~mapped;
		if (psel_in && !penable_in) begin
			st_next.prdata = mapped ? rd : frame_list_pkg::BUS_ERR_DATA;
		end

		// Software writes
		if (wr) begin
			case (paddr_in)
				frame_list_pkg::BULK_CUR_ADDR: begin
					// Ignored while the bulk list runs
					if (!st_reg.bulk_en) begin
						st_next.bulk_cur = pwdata_in & frame_list_pkg::PTR_MASK;
					end
				end
				frame_list_pkg::FM_INTV_ADDR: begin
					st_next.interval_toggle   = pwdata_in[frame_list_pkg::TOGGLE_BIT];
					st_next.full_speed_largest_packet = pwdata_in[frame_list_pkg::FULL_SPEED_LARGEST_PACKET_MSB:frame_list_pkg::FULL_SPEED_LARGEST_PACKET_LSB];
					st_next.fi    = pwdata_in[13:0];
				end
				frame_list_pkg::PER_START_ADDR: st_next.ps  = pwdata_in[13:0];
				frame_list_pkg::LS_THR_ADDR:    st_next.low_speed_threshold = pwdata_in[11:0];
				frame_list_pkg::CTRL_ADDR: begin
					st_next.bulk_en = pwdata_in[frame_list_pkg::CTRL_BULK_EN];
					st_next.filled  = pwdata_in[frame_list_pkg::CTRL_FILLED];
					st_next.oper    = pwdata_in[frame_list_pkg::CTRL_OPER];
					// Soft reset returns the interval word to nominal
					if (pwdata_in[frame_list_pkg::CTRL_SRST]) begin
						st_next.interval_toggle   = 1'b0;
						st_next.full_speed_largest_packet = frame_list_pkg::FULL_SPEED_LARGEST_PACKET_RST;
						st_next.fi    = frame_list_pkg::FI_NOMINAL;
						st_next.oper  = 1'b0;
					end
				end
				frame_list_pkg::STATUS_ADDR: begin
					// Write one to clear
					if (pwdata_in[frame_list_pkg::ST_SOF]) begin
						st_next.sf_st = 1'b0;
					end
					if (pwdata_in[frame_list_pkg::ST_WDH]) begin
						st_next.wdh_st = 1'b0;
					end
				end
				frame_list_pkg::INT_EN_ADDR: begin
					st_next.sf_en  = pwdata_in[frame_list_pkg::ST_SOF];
					st_next.wdh_en = pwdata_in[frame_list_pkg::ST_WDH];
					st_next.master_interrupt_enable    = pwdata_in[frame_list_pkg::EN_MIE];
				end
				default: ;
			endcase
		end

		// Bulk list walk; end of list wins over an advance
		if (bulk_end_in) begin
			if (st_reg.filled) begin
				st_next.bulk_cur = bulk_head_in & frame_list_pkg::PTR_MASK;
				// A software set in the same cycle survives
				if (!(wr && paddr_in == frame_list_pkg::CTRL_ADDR
						&& pwdata_in[frame_list_pkg::CTRL_FILLED])) begin
					st_next.filled = 1'b0;
				end
			end
		end else if (bulk_served_in) begin
			st_next.bulk_cur = bulk_next_in & frame_list_pkg::PTR_MASK;
		end

		// Done list: write back old head, then link the new descriptor
		if (done_wb_req_in) begin
			st_next.donewb_p    = 1'b1;
			st_next.donewb_data = st_reg.done_head;
			st_next.done_head   = frame_list_pkg::DONE_HEAD_RST;
			st_next.wdh_st      = 1'b1;
		end
		if (td_complete_in) begin
			st_next.tdwr_p    = 1'b1;
			st_next.tdwr_data = done_wb_req_in ? frame_list_pkg::DONE_HEAD_RST : st_reg.done_head;
			st_next.done_head = td_addr_in & frame_list_pkg::PTR_MASK;
		end

		// Frame timing
		if (st_reg.oper && !st_reg.oper_d) begin
			// Entry into operation reloads and counts a frame
			st_next.fr    = st_reg.fi;
			st_next.fn    = st_reg.fn + 16'h0001;
			st_next.lpc   = st_reg.full_speed_largest_packet;
			st_next.sof_p = 1'b1;
			st_next.prio  = 1'b0;
		end else if (st_reg.oper && tick) begin
			if (st_reg.fr == 14'h0000) begin
				// Reload at the boundary after zero
				st_next.fr    = st_reg.fi;
				st_next.fn    = st_reg.fn + 16'h0001;
				st_next.lpc   = st_reg.full_speed_largest_packet;
				st_next.sof_p = 1'b1;
				st_next.prio  = 1'b0;
			end else begin
				st_next.fr = st_reg.fr - 14'h0001;
				// Toggle follows the interval toggle as zero is reached
				if (st_reg.fr == 14'h0001) begin
					st_next.remaining_toggle = st_reg.interval_toggle;
				end
				// Periodic lists take over at the threshold
				if (st_reg.fr - 14'h0001 == st_reg.ps) begin
					st_next.prio = 1'b1;
				end
			end
		end

		// Frame number goes out one cycle after the frame start, together with the status
		if (st_reg.sof_p) begin
			st_next.fnwb_p = 1'b1;
			st_next.sf_st  = 1'b1;
		end

		// Periodic work starts once the current transaction ends
		st_next.pgo   = st_reg.prio & ~xact_busy_in;
		st_next.ls_ok = st_reg.fr >= {2'b00, st_reg.low_speed_threshold};
		st_next.irq   = st_reg.master_interrupt_enable & ((st_reg.sf_st & st_reg.sf_en)
			| (st_reg.wdh_st & st_reg.wdh_en));
	end

	// State register with defined reset values
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			st_reg             <= '0;
			st_reg.bulk_cur    <= frame_list_pkg::BULK_CUR_RST;
			st_reg.done_head   <= frame_list_pkg::DONE_HEAD_RST;
			st_reg.fi          <= frame_list_pkg::FI_NOMINAL;
			st_reg.full_speed_largest_packet       <= frame_list_pkg::FULL_SPEED_LARGEST_PACKET_RST;
			st_reg.ps          <= frame_list_pkg::PS_RST;
			st_reg.low_speed_threshold         <= frame_list_pkg::LST_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from the state register
	assign prdata_out               = st_reg.prdata;
	assign pready_out               = st_reg.pready;
	assign pslverr_out              = st_reg.pslverr;
	assign td_link_wr_out           = st_reg.tdwr_p;
	assign td_link_data_out         = st_reg.tdwr_data;
	assign done_wb_out              = st_reg.donewb_p;
	assign done_wb_data_out         = st_reg.donewb_data;
	assign sof_out                  = st_reg.sof_p;
	assign fn_wb_out                = st_reg.fnwb_p;
	assign frame_number_out         = st_reg.fn;
	assign bulk_current_out         = st_reg.bulk_cur;
	assign largest_packet_count_out = st_reg.lpc;
	assign periodic_priority_out    = st_reg.prio;
	assign periodic_go_out          = st_reg.pgo;
	assign ls_commit_ok_out         = st_reg.ls_ok;
	assign irq_out                  = st_reg.irq;

	// Checks on the block's own behaviour
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);

	// Served descriptor becomes the current pointer
	AST_BULK_ADVANCE: assert property (bulk_served_in && !bulk_end_in && !wr |=>
		bulk_current_out == ($past(bulk_next_in) & frame_list_pkg::PTR_MASK))
		else $error("bulk pointer did not advance");

	// End of list with filled flag reloads head and clears flag
	AST_BULK_WRAP: assert property (bulk_end_in && st_reg.filled && !wr |=>
		bulk_current_out == ($past(bulk_head_in) & frame_list_pkg::PTR_MASK) && !st_reg.filled)
		else $error("bulk wrap to head failed");

	// End of list without filled flag leaves the pointer alone
	AST_BULK_HOLD: assert property (bulk_end_in && !st_reg.filled && !wr |=>
		$stable(bulk_current_out))
		else $error("bulk pointer moved at list end");

	// Completed descriptor gets the old head, head takes its address
	AST_TD_LINK: assert property (td_complete_in && !done_wb_req_in |=>
		td_link_wr_out && td_link_data_out == $past(st_reg.done_head)
		&& st_reg.done_head == ($past(td_addr_in) & frame_list_pkg::PTR_MASK))
		else $error("done list link wrong");

	// Writeback clears the head and sets its status
	AST_DONE_WB: assert property (done_wb_req_in && !td_complete_in |=>
		done_wb_out && st_reg.done_head == 32'h00000000 && st_reg.wdh_st)
		else $error("done head writeback wrong");

	// Reload after zero steps the frame number
	AST_FR_RELOAD: assert property (st_reg.oper && st_reg.oper_d && tick && st_reg.fr == 14'h0000 |=>
		st_reg.fr == $past(st_reg.fi) && frame_number_out == 16'($past(st_reg.fn) + 16'h0001))
		else $error("frame reload wrong");

	// Toggle copied when the counter reaches zero
	AST_FRT: assert property (st_reg.oper && st_reg.oper_d && tick && st_reg.fr == 14'h0001 |=>
		st_reg.remaining_toggle == $past(st_reg.interval_toggle) && st_reg.fr == 14'h0000)
		else $error("remaining toggle not loaded");

	// Entering operation reloads and counts
	AST_OPER_ENTRY: assert property ($rose(st_reg.oper) |=>
		st_reg.fr == $past(st_reg.fi) && frame_number_out == 16'($past(st_reg.fn) + 16'h0001))
		else $error("operational entry reload wrong");

	// Frame number write one cycle after frame start, with status
	AST_SOF_ORDER: assert property (sof_out |=> fn_wb_out && st_reg.sf_st ##1 !fn_wb_out)
		else $error("frame number write order wrong");

	// Low speed commit follows the comparison
	AST_LS_OK: assert property (##1 ls_commit_ok_out == ($past(st_reg.fr) >= 14'($past(st_reg.low_speed_threshold))))
		else $error("low speed commit wrong");

	// Interrupt only under master enable
	AST_IRQ: assert property (irq_out |-> $past(st_reg.master_interrupt_enable))
		else $error("interrupt without master enable");

	// Software write to the bulk pointer is dropped while the list runs
	AST_BULK_SW_REFUSE: assert property (wr && paddr_in == frame_list_pkg::BULK_CUR_ADDR && st_reg.bulk_en
		&& !bulk_served_in && !bulk_end_in |=> $stable(bulk_current_out))
		else $error("bulk pointer written while enabled");

	// Priority rises as the counter steps onto the periodic start
	AST_PRIO_SET: assert property (st_reg.oper && st_reg.oper_d && tick && st_reg.fr != 14'h0000
		&& st_reg.fr - 14'h0001 == st_reg.ps |=> periodic_priority_out)
		else $error("periodic priority not raised");

	// Periodic start waits for the running transaction
	AST_PGO: assert property (##1 periodic_go_out == ($past(st_reg.prio) && !$past(xact_busy_in)))
		else $error("periodic start decision wrong");

	// Largest packet counter loaded with every frame start
	AST_LPC_LOAD: assert property (sof_out |-> largest_packet_count_out == $past(st_reg.full_speed_largest_packet))
		else $error("largest packet counter not loaded");
endmodule

/* File: frame_list_pkg.sv */
/*
 Constants, field layouts and the state record of the frame timing and
 list pointer block of a USB host controller.
 Assumes a 32-bit APB register bus and a 10 MHz controller clock.
*/
// Functional notes
// - Bulk pointer advances after each served descriptor
// - Bulk end: if filled, reload head, clear flag
// - Bulk pointer resets to zero, marks end
// - Completed descriptor links old done head first
// - Done head writeback clears head, sets status
// - Frame interval resets to 11999 nominal
// - Largest packet counter loaded every frame start
// - Remaining counter decrements, reloads after zero
// - Entering operational reloads remaining from interval
// - Remaining toggle copies interval toggle at zero
// - Frame number increments per reload, wraps
// - Frame number increments on entering operational
// - Frame number written out, then status set (here both in the same cycle)
// - Periodic start clears on hardware reset
// - Periodic lists win once start reached
// - Low speed only if remaining >= threshold
// - Reserved bits read as zero here
// - Event interrupt needs own and master enable
package frame_list_pkg;
	// Register byte addresses
	localparam logic [31:0] BULK_CUR_ADDR  = 32'h8002002C;
	localparam logic [31:0] DONE_HEAD_ADDR = 32'h80020030;
	localparam logic [31:0] FM_INTV_ADDR   = 32'h80020034;
	localparam logic [31:0] FM_REM_ADDR    = 32'h80020038;
	localparam logic [31:0] FM_NUM_ADDR    = 32'h8002003C;
	localparam logic [31:0] PER_START_ADDR = 32'h80020040;
	localparam logic [31:0] LS_THR_ADDR    = 32'h80020044;
	localparam logic [31:0] CTRL_ADDR      = 32'h80020080;
	localparam logic [31:0] STATUS_ADDR    = 32'h80020084;
	localparam logic [31:0] INT_EN_ADDR    = 32'h80020088;
	// Pointer field mask, bits 31:4
	localparam logic [31:0] PTR_MASK       = 32'hFFFFFFF0;
	// Field positions
	localparam int TOGGLE_BIT  = 31;
	localparam int FULL_SPEED_LARGEST_PACKET_LSB   = 16;
	localparam int FULL_SPEED_LARGEST_PACKET_MSB   = 30;
	localparam int CTRL_BULK_EN = 0;
	localparam int CTRL_FILLED  = 1;
	localparam int CTRL_OPER    = 2;
	localparam int CTRL_SRST    = 3;
	localparam int ST_SOF       = 0;
	localparam int ST_WDH       = 1;
	localparam int EN_MIE       = 31;
	// Reset values
	localparam logic [31:0] BULK_CUR_RST  = 32'h00000000;
	localparam logic [31:0] DONE_HEAD_RST = 32'h00000000;
	localparam logic [13:0] FI_NOMINAL    = 14'h2EDF;
	localparam logic [14:0] FULL_SPEED_LARGEST_PACKET_RST     = 15'h0000;
	localparam logic [13:0] PS_RST        = 14'h0000;
	localparam logic [11:0] LST_RST       = 12'h628;
	localparam logic [31:0] BUS_ERR_DATA  = 32'h00000000;

	// Whole state of the timing block
	typedef struct packed {
		logic [31:0] bulk_cur;
		logic [31:0] done_head;
		logic        interval_toggle;
		logic [14:0] full_speed_largest_packet;
		logic [13:0] fi;
		logic        remaining_toggle;
		logic [13:0] fr;
		logic [15:0] fn;
		logic [13:0] ps;
		logic [11:0] low_speed_threshold;
		logic        bulk_en;
		logic        filled;
		logic        oper;
		logic        oper_d;
		logic        sf_st;
		logic        wdh_st;
		logic        sf_en;
		logic        wdh_en;
		logic        master_interrupt_enable;
		logic [14:0] lpc;
		logic        sof_p;
		logic        fnwb_p;
		logic        tdwr_p;
		logic [31:0] tdwr_data;
		logic        donewb_p;
		logic [31:0] donewb_data;
		logic        prio;
		logic        pgo;
		logic        ls_ok;
		logic        irq;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
		logic        tick_d;
	} state_t;
endpackage

/* File: bit_tick_sync.sv */
/*
 Two-stage synchroniser for the bit-time strobe of the serial engine.
 Assumes the strobe is a level that holds for at least two controller clocks.
*/
`timescale 1ns/1ps
module bit_tick_sync (
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic rstn_in,
	// Asynchronous level and its synchronised copy
	input  wire logic level_in,
	output logic      level_out
);
	// First and second stage flops
	logic first_reg;
	logic second_reg;

	// Only the second stage reads the first
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			first_reg  <= 1'b0;
			second_reg <= 1'b0;
		end else begin
			first_reg  <= level_in;
			second_reg <= first_reg;
		end
	end

	assign level_out = second_reg;
endmodule

/* File: frame_list_timer_test.sv */
/*
 Self-checking bench of the frame timing and list pointer block.
 Assumes the block alone on a 10 MHz clock, driven over APB and list pins.
*/
`timescale 1ns/1ps
module frame_list_timer_test;
	logic        clk_in, rstn_in;                      // Clock and reset
	logic        psel_in, penable_in, pwrite_in;       // APB control
	logic [31:0] paddr_in, pwdata_in, prdata_out;      // APB address and data
	logic        pready_out, pslverr_out;              // APB answer
	logic        bit_tick_in, xact_busy_in;            // Bit strobe, busy level
	logic        bulk_served_in, bulk_end_in;          // Bulk list events
	logic        td_complete_in, done_wb_req_in;       // Done list events
	logic [31:0] bulk_next_in, bulk_head_in, td_addr_in; // Event data
	logic        td_link_wr_out, done_wb_out;          // Shared area writes
	logic [31:0] td_link_data_out, done_wb_data_out;   // Shared area data
	logic        sof_out, fn_wb_out, irq_out;          // Frame events
	logic [15:0] frame_number_out;                     // Frame number
	logic [31:0] bulk_current_out;                     // Bulk pointer
	logic [14:0] largest_packet_count_out;             // Largest packet counter
	logic        periodic_priority_out, periodic_go_out, ls_commit_ok_out; // Decisions
	logic [32:0] rd_q[$];                              // Expected reads, error bit on top
	logic [32:0] ev_q[$];                              // Expected writes, kind bit on top
	int          n_mismatch, n_compared, cycles;       // Counters
	logic [31:0] p1, p2;                               // Random pointers
	int          n_sof, n_fnwb;                        // Frame start and number write pulses

	// Device under test
	frame_list_timer i_dut (
		.clk_in(clk_in), .rstn_in(rstn_in),
		.psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
		.paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
		.pready_out(pready_out), .pslverr_out(pslverr_out),
		.bit_tick_in(bit_tick_in),
		.bulk_served_in(bulk_served_in), .bulk_next_in(bulk_next_in),
		.bulk_end_in(bulk_end_in), .bulk_head_in(bulk_head_in),
		.td_complete_in(td_complete_in), .td_addr_in(td_addr_in),
		.done_wb_req_in(done_wb_req_in), .xact_busy_in(xact_busy_in),
		.td_link_wr_out(td_link_wr_out), .td_link_data_out(td_link_data_out),
		.done_wb_out(done_wb_out), .done_wb_data_out(done_wb_data_out),
		.sof_out(sof_out), .fn_wb_out(fn_wb_out), .frame_number_out(frame_number_out),
		.bulk_current_out(bulk_current_out), .largest_packet_count_out(largest_packet_count_out),
		.periodic_priority_out(periodic_priority_out), .periodic_go_out(periodic_go_out),
		.ls_commit_ok_out(ls_commit_ok_out), .irq_out(irq_out)
	);

	// Clock of 100 ns
	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end

	// Cuts a hang short
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 5000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	// Compares one value with its expectation
	task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask

	// Prints the counts and the verdict
	task automatic tally_and_finish;
		$display("compared %0d, mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// One APB transfer, held until pready is seen
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk_in);
		psel_in    <= 1'b1;
		penable_in <= 1'b0;
		pwrite_in  <= w;
		paddr_in   <= a;
		pwdata_in  <= d;
		@(posedge clk_in);
		penable_in <= 1'b1;
		do begin
			@(posedge clk_in);
		end while (pready_out !== 1'b1);
		psel_in    <= 1'b0;
		penable_in <= 1'b0;
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	// Read, noting the expected word first
	task automatic rd(input logic [31:0] a, input logic [31:0] d, input logic e = 1'b0);
		rd_q.push_back({e, d});
		apb(1'b0, a, 32'h0);
	endtask

	// One-cycle list engine event: served, end, complete, writeback
	task automatic pulse(input logic [3:0] k, input logic [31:0] v);
		@(posedge clk_in);
		bulk_served_in <= k[0];
		bulk_end_in    <= k[1];
		td_complete_in <= k[2];
		done_wb_req_in <= k[3];
		bulk_next_in   <= v;
		bulk_head_in   <= v;
		td_addr_in     <= v;
		@(posedge clk_in);
		{bulk_served_in, bulk_end_in, td_complete_in, done_wb_req_in} <= 4'h0;
		@(posedge clk_in);
		#1;
	endtask

	// One bit time, held three clocks high and three low
	task automatic tick;
		@(posedge clk_in);
		bit_tick_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		bit_tick_in <= 1'b0;
		repeat (3) @(posedge clk_in);
		#1;
	endtask

	// Watches answers and takes the oldest note for each
	always @(posedge clk_in) begin
		if (psel_in && penable_in && !pwrite_in && pready_out === 1'b1) begin
			chk({pslverr_out, prdata_out}, rd_q.size() ? rd_q.pop_front() : 33'hX);
		end
		if (td_link_wr_out === 1'b1) begin
			chk({1'b0, td_link_data_out}, ev_q.size() ? ev_q.pop_front() : 33'hX);
		end
		if (done_wb_out === 1'b1) begin
			chk({1'b1, done_wb_data_out}, ev_q.size() ? ev_q.pop_front() : 33'hX);
		end
		// Frame start and frame number write pulses are counted
		if (sof_out === 1'b1) begin
			n_sof++;
		end
		if (fn_wb_out === 1'b1) begin
			n_fnwb++;
		end
	end

	// Main sequence
	initial begin
		{psel_in, penable_in, pwrite_in, bit_tick_in} = 4'h0;
		{bulk_served_in, bulk_end_in, td_complete_in, done_wb_req_in} = 4'h0;
		{paddr_in, pwdata_in, bulk_next_in, bulk_head_in, td_addr_in} = '0;
		xact_busy_in = 1'b1;
		rstn_in      = 1'b0;
		n_mismatch   = 0;
		n_compared   = 0;
		cycles       = 0;
		n_sof        = 0;
		n_fnwb       = 0;
		void'($urandom(3));
		repeat (6) @(posedge clk_in);
		rstn_in <= 1'b1;
		// Reset values and an unmapped place
		rd(frame_list_pkg::BULK_CUR_ADDR, 32'h00000000);
		rd(frame_list_pkg::DONE_HEAD_ADDR, 32'h00000000);
		rd(frame_list_pkg::FM_INTV_ADDR, 32'h00002EDF);
		rd(frame_list_pkg::FM_REM_ADDR, 32'h00000000);
		rd(frame_list_pkg::FM_NUM_ADDR, 32'h00000000);
		rd(frame_list_pkg::PER_START_ADDR, 32'h00000000);
		rd(frame_list_pkg::LS_THR_ADDR, 32'h00000628);
		rd(32'h80020048, 32'h00000000, 1'b1);
		$display("test reset values done");
		// Bulk pointer: written while idle, refused while enabled
		p1 = $urandom();
		wr(frame_list_pkg::BULK_CUR_ADDR, p1);
		rd(frame_list_pkg::BULK_CUR_ADDR, p1 & frame_list_pkg::PTR_MASK);
		wr(frame_list_pkg::CTRL_ADDR, 32'h00000001);
		wr(frame_list_pkg::BULK_CUR_ADDR, ~p1);
		rd(frame_list_pkg::BULK_CUR_ADDR, p1 & frame_list_pkg::PTR_MASK);
		p2 = $urandom() & frame_list_pkg::PTR_MASK;
		pulse(4'b0001, p2);
		chk({1'b0, bulk_current_out}, {1'b0, p2});
		// End of list: no reload while the flag is clear, reload once set
		p1 = $urandom() & frame_list_pkg::PTR_MASK;
		pulse(4'b0010, p1);
		chk({1'b0, bulk_current_out}, {1'b0, p2});
		wr(frame_list_pkg::CTRL_ADDR, 32'h00000003);
		pulse(4'b0010, p1);
		chk({1'b0, bulk_current_out}, {1'b0, p1});
		rd(frame_list_pkg::CTRL_ADDR, 32'h00000001);
		$display("test bulk list done");
		// Done list: link old head, then writeback clears it
		ev_q.push_back({1'b0, 32'h0});
		pulse(4'b0100, p1);
		ev_q.push_back({1'b0, p1});
		pulse(4'b0100, p2);
		rd(frame_list_pkg::DONE_HEAD_ADDR, p2);
		ev_q.push_back({1'b1, p2});
		pulse(4'b1000, 32'h0);
		rd(frame_list_pkg::DONE_HEAD_ADDR, 32'h0);
		rd(frame_list_pkg::STATUS_ADDR, 32'h2);
		wr(frame_list_pkg::STATUS_ADDR, 32'h2);
		chk({32'h0, ev_q.size() == 0}, 33'h1);
		$display("test done list done");
		// Frame timing: interval 4, largest 0x123, periodic 2, threshold 3
		wr(frame_list_pkg::PER_START_ADDR, 32'h2);
		wr(frame_list_pkg::LS_THR_ADDR, 32'h3);
		wr(frame_list_pkg::FM_INTV_ADDR, 32'h81230004);
		rd(frame_list_pkg::FM_INTV_ADDR, 32'h81230004);
		wr(frame_list_pkg::INT_EN_ADDR, 32'h80000001);
		wr(frame_list_pkg::CTRL_ADDR, 32'h00000004);
		repeat (3) @(posedge clk_in);
		rd(frame_list_pkg::FM_REM_ADDR, 32'h4);
		rd(frame_list_pkg::FM_NUM_ADDR, 32'h1);
		#1 chk({18'h0, largest_packet_count_out}, 33'h123);
		chk({32'h0, irq_out}, 33'h1);
		wr(frame_list_pkg::STATUS_ADDR, 32'h1);
		repeat (2) @(posedge clk_in);
		#1 chk({32'h0, irq_out}, 33'h0);
		tick();
		chk({31'h0, ls_commit_ok_out, periodic_priority_out}, 33'h2);
		tick();
		chk({31'h0, ls_commit_ok_out, periodic_priority_out}, 33'h1);
		chk({32'h0, periodic_go_out}, 33'h0);
		@(posedge clk_in);
		xact_busy_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		#1 chk({32'h0, periodic_go_out}, 33'h1);
		tick();
		tick();
		rd(frame_list_pkg::FM_REM_ADDR, 32'h80000000);
		tick();
		rd(frame_list_pkg::FM_REM_ADDR, 32'h80000004);
		rd(frame_list_pkg::FM_NUM_ADDR, 32'h2);
		chk({17'h0, frame_number_out}, 33'h2);
		chk({1'b0, 16'(n_sof), 16'(n_fnwb)}, 33'h20002);
		chk({32'h0, periodic_priority_out}, 33'h0);
		chk({32'h0, irq_out}, 33'h1);
		wr(frame_list_pkg::INT_EN_ADDR, 32'h00000001);
		repeat (2) @(posedge clk_in);
		#1 chk({32'h0, irq_out}, 33'h0);
		$display("test frame timing done");
		// Soft reset restores the interval and keeps the periodic start
		rd(frame_list_pkg::FM_INTV_ADDR, 32'h81230004);
		wr(frame_list_pkg::CTRL_ADDR, 32'h00000008);
		repeat (2) @(posedge clk_in);
		rd(frame_list_pkg::FM_INTV_ADDR, 32'h00002EDF);
		rd(frame_list_pkg::PER_START_ADDR, 32'h2);
		// Saved interval written back, toggle flipped from its reset value
		wr(frame_list_pkg::FM_INTV_ADDR, 32'h81230004);
		rd(frame_list_pkg::FM_INTV_ADDR, 32'h81230004);
		repeat (2) @(posedge clk_in);
		$display("test soft reset done");
		tally_and_finish();
	end
endmodule
